// ### sfrc_core.sv
/*
  Serial flash front end: page read, buffer read, status read, page to
  buffer transfer and page to buffer compare, with the main array and
  both data buffers held here.
  Assumes a host that keeps chip select low for whole frames, drives
  si on the shift clock in mode 0 or 3, and a program path on clk_in
  that writes the main array and reports its own busy level.
*/
// Function
// - frame opens on chip select fall, then 8-bit opcode, then address field
// - opcode, address and data all travel most significant bit first
// - first 32 shift clock rises load opcode and address bits while chip select low
// - page read is 52H, 24 address bits, 32 don't-care bits
// - page read address: 5 reserved, 10-bit page, 9-bit byte offset
// - after last page read don't-care bit, one data bit per clock
// - page read takes main array directly, buffers untouched
// - page read wraps to byte zero of same page
// - chip select rise ends read and floats serial output
// - 54H reads buffer one, 56H reads buffer two
// - buffer read: opcode, 15 don't-care, 9-bit offset, 8 don't-care
// - buffer read wraps to byte zero of same buffer
// - transfer is 53H or 55H, 5 reserved, page, 9 don't-care
// - copy starts only at chip select rise after transfer frame
// - status reads are answered while a copy runs
// - compare is 60H or 61H with 24-bit page address
// - compare of all 264 bytes starts at chip select rise, busy meanwhile
// - compare outcome lands in status bit 6, held until next compare
// - modes 0 and 3 both work, input sampled on rising edge
// - status bit 6 is 0 on exact match, 1 on any difference
// - status read 57H streams eight status bits repeatedly
// - status bit 7 is 1 when ready, 0 while busy
`timescale 1ns/10ps
`default_nettype none
`include "sfrc_regs.svh"

module sfrc_core #(
  parameter int unsigned COPY_CYCLES =
    (`SFRC_PAGE_COPY_TIME_NS + `SFRC_CLK_PERIOD_NS - 1) / `SFRC_CLK_PERIOD_NS,
  parameter logic [2:0] DENSITY_CODE = 3'h0  // arbitrary value
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic prog_we_in,
  input wire logic [9:0] prog_page_in,
  input wire logic [8:0] prog_byte_in,
  input wire logic [7:0] prog_data_in,
  input wire logic prog_busy_in,
  input wire logic prog_buf_sel_in,
  input wire logic [8:0] prog_buf_byte_in,
  output logic [7:0] prog_buf_data_out,
  output logic ready_out
);

  localparam int unsigned MAIN_WORDS = `SFRC_PAGES * `SFRC_PAGE_BYTES;
  localparam int unsigned BUF_WORDS = 2 * `SFRC_PAGE_BYTES;

  logic [7:0] main_mem [0:MAIN_WORDS-1];
  logic [7:0] buf_mem [0:BUF_WORDS-1];

  function automatic logic [18:0] main_idx(input logic [9:0] page, input logic [8:0] off);
    main_idx = 19'(page) * 19'(`SFRC_PAGE_BYTES) + 19'(off);
  endfunction

  function automatic logic [9:0] buf_idx(input logic sel, input logic [8:0] off);
    buf_idx = (sel ? 10'(`SFRC_PAGE_BYTES) : 10'h000) + 10'(off);
  endfunction

  // ----------------------------------------------------------------
  // link side: shift clock domain
  // ----------------------------------------------------------------
  // chip select high clears the frame at once; the shift clock may be
  // stopped, so no sck edge can be relied on to end the frame
  logic frame_rst_n;
  assign frame_rst_n = reset_n_in & ~cs_n_in;

  logic [6:0] cnt_reg;
  logic [7:0] op_reg;
  logic [23:0] addr_reg;
  logic [2:0] bit_reg;
  logic [8:0] ptr_reg;
  logic cmd_tog_reg;
  logic [7:0] st_s1_reg;
  logic [7:0] st_s2_reg;
  logic so_reg;
  logic so_oe_reg;
  logic [6:0] pre_len;
  logic is_page_rd;
  logic is_buf_rd;
  logic is_job_op;
  logic data_active;
  logic [7:0] rd_byte;

  always_comb begin
    is_page_rd = (op_reg == `SFRC_OP_PAGE_READ);
    is_buf_rd = (op_reg == `SFRC_OP_BUF1_READ) || (op_reg == `SFRC_OP_BUF2_READ);
    is_job_op = (op_reg == `SFRC_OP_XFER_BUF1) || (op_reg == `SFRC_OP_XFER_BUF2) ||
                (op_reg == `SFRC_OP_CMP_BUF1) || (op_reg == `SFRC_OP_CMP_BUF2);
    if (is_page_rd) begin
      pre_len = `SFRC_PAGE_READ_PRE;
    end else if (is_buf_rd) begin
      pre_len = `SFRC_BUF_READ_PRE;
    end else if (op_reg == `SFRC_OP_STATUS) begin
      pre_len = `SFRC_STATUS_PRE;
    end else begin
      pre_len = `SFRC_NO_DATA_PRE;
    end
    data_active = (cnt_reg >= `SFRC_OP_BITS) && (cnt_reg >= pre_len) &&
                  (pre_len != `SFRC_NO_DATA_PRE);
  end

  // edge counter, saturating past the longest preamble
  always_ff @(posedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_reg <= 7'h00;
    end else if (cnt_reg != `SFRC_CNT_MAX) begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  // opcode and address shift in msb first on the rising edge
  always_ff @(posedge sck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end else if (!cs_n_in) begin
      if (cnt_reg < `SFRC_OP_BITS) begin
        op_reg <= {op_reg[6:0], si_in};
      end else if (cnt_reg < `SFRC_ADDR_END) begin
        addr_reg <= {addr_reg[22:0], si_in};
      end
    end
  end

  // byte pointer: loaded from the 9-bit offset during the preamble,
  // then stepped every eight data clocks with wrap inside the page
  always_ff @(posedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_reg <= 3'h0;
      ptr_reg <= 9'h000;
    end else if (!data_active) begin
      bit_reg <= 3'h0;
      ptr_reg <= (addr_reg[8:0] > `SFRC_LAST_BYTE) ? 9'h000 : addr_reg[8:0];
    end else begin
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        ptr_reg <= (ptr_reg == `SFRC_LAST_BYTE) ? 9'h000 : ptr_reg + 9'h001;
      end
    end
  end

  // one toggle per finished transfer or compare frame; not cleared by
  // chip select, so the clk side sees it after the frame ends
  always_ff @(posedge sck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_tog_reg <= 1'b0;
    end else if (!cs_n_in && (cnt_reg == `SFRC_ADDR_END - 7'h01) && is_job_op) begin
      cmd_tog_reg <= ~cmd_tog_reg;
    end
  end

  sfrc_pkg::sfrc_status_s status_reg;

  // status byte crosses bit by bit; ready and compare are slow levels,
  // the first status byte of a frame may lag by two sck edges
  always_ff @(posedge sck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_s1_reg <= 8'h00;
      st_s2_reg <= 8'h00;
    end else begin
      st_s1_reg <= status_reg;
      st_s2_reg <= st_s1_reg;
    end
  end

  // main array read is direct, buffers are not touched
  always_comb begin
    if (is_page_rd) begin
      rd_byte = main_mem[main_idx(addr_reg[18:9], ptr_reg)];
    end else if (is_buf_rd) begin
      rd_byte = buf_mem[buf_idx(op_reg == `SFRC_OP_BUF2_READ, ptr_reg)];
    end else begin
      rd_byte = st_s2_reg;
    end
  end

  // output changes on the falling edge so the host samples it on the
  // rising one in either mode
  always_ff @(negedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg <= rd_byte[3'h7 - bit_reg];
      so_oe_reg <= data_active;
    end
  end

  assign so_out = so_reg;
  assign so_oe_out = so_oe_reg;

  // ----------------------------------------------------------------
  // core side: clk_in domain
  // ----------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic pending_reg;
  logic cs_rise;
  logic cs_fall;
  logic launch;
  logic busy;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      tog_s1_reg <= cmd_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  sfrc_pkg::sfrc_eng_e eng_reg;

  assign cs_rise = cs_s2_reg && !cs_s3_reg;
  assign cs_fall = !cs_s2_reg && cs_s3_reg;
  assign busy = (eng_reg != sfrc_pkg::SFRC_ENG_IDLE) || prog_busy_in;
  assign launch = cs_rise && pending_reg && !busy;

  // a finished frame waits for chip select to rise; a new edge of the
  // toggle wins over the clear at a frame start
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_reg <= 1'b0;
    end else if (tog_s2_reg != tog_s3_reg) begin
      pending_reg <= 1'b1;
    end else if (cs_fall || cs_rise) begin
      pending_reg <= 1'b0;
    end
  end

  sfrc_pkg::sfrc_job_s job_reg;
  logic [12:0] timer_reg;
  logic [8:0] idx_reg;
  logic mismatch_reg;
  logic cmp_bit_reg;
  logic eng_last;
  logic byte_step;
  logic buf_we;
  logic [7:0] main_byte;

  // op and address stay still once sck has stopped at the frame end,
  // so they are read across the boundary only at launch
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      job_reg <= '0;
    end else if (launch) begin
      job_reg.is_cmp <= (op_reg == `SFRC_OP_CMP_BUF1) || (op_reg == `SFRC_OP_CMP_BUF2);
      job_reg.buf_sel <= (op_reg == `SFRC_OP_XFER_BUF2) || (op_reg == `SFRC_OP_CMP_BUF2);
      job_reg.page_number_bits <= addr_reg[18:9];
    end
  end

  assign eng_last = (timer_reg == 13'(COPY_CYCLES - 1));
  assign byte_step = (eng_reg != sfrc_pkg::SFRC_ENG_IDLE) && (idx_reg <= `SFRC_LAST_BYTE);
  assign buf_we = byte_step && (eng_reg == sfrc_pkg::SFRC_ENG_XFER);
  assign main_byte = main_mem[main_idx(job_reg.page_number_bits, idx_reg)];

  // one byte per cycle, then the rest of the copy time stays busy;
  // COPY_CYCLES must exceed the page length
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      eng_reg <= sfrc_pkg::SFRC_ENG_IDLE;
      timer_reg <= 13'h0000;
      idx_reg <= 9'h000;
    end else begin
      unique case (eng_reg)
        sfrc_pkg::SFRC_ENG_IDLE: begin
          timer_reg <= 13'h0000;
          idx_reg <= 9'h000;
          if (launch) begin
            if ((op_reg == `SFRC_OP_CMP_BUF1) || (op_reg == `SFRC_OP_CMP_BUF2)) begin
              eng_reg <= sfrc_pkg::SFRC_ENG_CMP;
            end else begin
              eng_reg <= sfrc_pkg::SFRC_ENG_XFER;
            end
          end
        end
        sfrc_pkg::SFRC_ENG_XFER, sfrc_pkg::SFRC_ENG_CMP: begin
          timer_reg <= timer_reg + 13'h0001;
          if (byte_step) begin
            idx_reg <= idx_reg + 9'h001;
          end
          if (eng_last) begin
            eng_reg <= sfrc_pkg::SFRC_ENG_IDLE;
          end
        end
      endcase
    end
  end

  // buffer fill during a transfer only
  always_ff @(posedge clk_in) begin
    if (buf_we) begin
      buf_mem[buf_idx(job_reg.buf_sel, idx_reg)] <= main_byte;
    end
  end

  // program path writes into the main array
  always_ff @(posedge clk_in) begin
    if (prog_we_in) begin
      main_mem[main_idx(prog_page_in, prog_byte_in)] <= prog_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_buf_data_out <= 8'h00;
    end else begin
      prog_buf_data_out <= buf_mem[buf_idx(prog_buf_sel_in, prog_buf_byte_in)];
    end
  end

  // compare accumulates any differing bit, result lands at the end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mismatch_reg <= 1'b0;
      cmp_bit_reg <= `SFRC_CMP_RESET;
    end else begin
      if (launch) begin
        mismatch_reg <= 1'b0;
      end else if (byte_step && (eng_reg == sfrc_pkg::SFRC_ENG_CMP)) begin
        if (main_byte != buf_mem[buf_idx(job_reg.buf_sel, idx_reg)]) begin
          mismatch_reg <= 1'b1;
        end
      end
      if ((eng_reg == sfrc_pkg::SFRC_ENG_CMP) && eng_last) begin
        cmp_bit_reg <= mismatch_reg;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_reg <= '0;
    end else begin
      status_reg.ready <= !busy;
      status_reg.cmp_diff <= cmp_bit_reg;
      status_reg.density <= DENSITY_CODE;
      status_reg.rsvd <= 3'h0;
    end
  end

  assign ready_out = status_reg.ready;

  // ----------------------------------------------------------------
  // checks, core side
  // ----------------------------------------------------------------
  sequence s_job_launch;
    launch;
  endsequence

  sequence s_busy_run;
    (eng_reg != sfrc_pkg::SFRC_ENG_IDLE) [*8];
  endsequence

  property p_busy_after_cmd;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_job_launch |=> s_busy_run;
  endproperty
  a_busy_after_cmd: assert property (p_busy_after_cmd)
    else $error("engine did not run after a launch");

  property p_launch_on_rise;
    @(posedge clk_in) disable iff (!reset_n_in)
      ((eng_reg == sfrc_pkg::SFRC_ENG_IDLE) && !cs_rise)
        |=> (eng_reg == sfrc_pkg::SFRC_ENG_IDLE);
  endproperty
  a_launch_on_rise: assert property (p_launch_on_rise)
    else $error("job launched without chip select rising");

  property p_status_busy;
    @(posedge clk_in) disable iff (!reset_n_in)
      (eng_reg != sfrc_pkg::SFRC_ENG_IDLE) |=> !status_reg.ready;
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("ready shown while engine runs");

  property p_cmp_update;
    @(posedge clk_in) disable iff (!reset_n_in)
      ((eng_reg == sfrc_pkg::SFRC_ENG_CMP) && eng_last)
        |=> (cmp_bit_reg == $past(mismatch_reg)) ##1 (status_reg.cmp_diff == cmp_bit_reg);
  endproperty
  a_cmp_update: assert property (p_cmp_update)
    else $error("compare outcome not stored");

  property p_cmp_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      !((eng_reg == sfrc_pkg::SFRC_ENG_CMP) && eng_last) |=> $stable(cmp_bit_reg);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("compare bit changed outside a compare end");

  property p_buf_only_xfer;
    @(posedge clk_in) disable iff (!reset_n_in)
      buf_we |-> !job_reg.is_cmp;
  endproperty
  a_buf_only_xfer: assert property (p_buf_only_xfer)
    else $error("buffer written outside a transfer");

  property p_cs_float;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cs_n_in && $past(cs_n_in)) |-> !so_oe_out;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("serial output driven with chip select high");

  // ----------------------------------------------------------------
  // checks, link side
  // ----------------------------------------------------------------
  property p_preamble_float;
    @(posedge sck_in) disable iff (!frame_rst_n)
      (cnt_reg < pre_len) |-> !so_oe_out;
  endproperty
  a_preamble_float: assert property (p_preamble_float)
    else $error("serial output driven before the data phase");

  property p_page_wrap;
    @(posedge sck_in) disable iff (!frame_rst_n)
      (data_active && bit_reg == 3'h7 && ptr_reg == `SFRC_LAST_BYTE) |=> (ptr_reg == 9'h000);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("read did not wrap to byte zero");

  property p_read_start;
    @(posedge sck_in) disable iff (!frame_rst_n)
      (is_page_rd && cnt_reg == `SFRC_PAGE_READ_PRE - 7'h01) |=> data_active ##1 so_oe_out;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("page read data phase did not open");

endmodule

`default_nettype wire

// ### sfrc_regs.svh
/*
  Constants of the serial flash read, transfer and compare front end:
  operation codes, frame lengths, array geometry and timing counts.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef SFRC_REGS_SVH
`define SFRC_REGS_SVH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define SFRC_OP_PAGE_READ 8'h52
`define SFRC_OP_BUF1_READ 8'h54
`define SFRC_OP_BUF2_READ 8'h56
`define SFRC_OP_XFER_BUF1 8'h53
`define SFRC_OP_XFER_BUF2 8'h55
`define SFRC_OP_CMP_BUF1 8'h60
`define SFRC_OP_CMP_BUF2 8'h61
`define SFRC_OP_STATUS 8'h57

// ----------------------------------------------------------------
// frame layout, counted in shift clock edges
// ----------------------------------------------------------------
`define SFRC_OP_BITS 7'h08
`define SFRC_ADDR_END 7'h20
`define SFRC_PAGE_READ_PRE 7'h40
`define SFRC_BUF_READ_PRE 7'h28
`define SFRC_STATUS_PRE 7'h08
`define SFRC_NO_DATA_PRE 7'h7F
`define SFRC_CNT_MAX 7'h7F

// ----------------------------------------------------------------
// geometry and reset values
// ----------------------------------------------------------------
`define SFRC_PAGES 1024
`define SFRC_PAGE_BYTES 264
`define SFRC_LAST_BYTE 9'h107
`define SFRC_CMP_RESET 1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFRC_CLK_PERIOD_NS 20
`define SFRC_PAGE_COPY_TIME_NS 120000

`endif

// ### sfrc_pkg.sv
/*
  Types shared by the serial flash read, transfer and compare front end.
  Assumes sfrc_regs.svh supplies the numeric constants.
*/
`default_nettype none
package sfrc_pkg;

  // --------------------------------------------------------------
  // status byte, shifted out msb first
  // --------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic cmp_diff;
    logic [2:0] density;
    logic [2:0] rsvd;
  } sfrc_status_s;

  // --------------------------------------------------------------
  // background copy or compare request
  // --------------------------------------------------------------
  typedef struct packed {
    logic is_cmp;
    logic buf_sel;
    logic [9:0] page_number_bits;
  } sfrc_job_s;

  typedef enum logic [1:0] {
    SFRC_ENG_IDLE,
    SFRC_ENG_XFER,
    SFRC_ENG_CMP
  } sfrc_eng_e;

endpackage
`default_nettype wire

// ### sfrc_host.sv
/*
  Host model for the serial flash front end: runs whole frames on
  cs/sck/si and collects the bytes read from so.
  Assumes the device drives so on falling shift clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
module sfrc_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  logic [7:0] rd_q[$];
  logic oe_early;
  logic oe_data;

  // time-zero nba, so the core sees its frame reset edge
  initial begin
    sck_out <= 1'b0;
    cs_n_out <= 1'b1;
    si_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame; shift clock stands still outside it
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nrd,
                       input logic m3);
    logic [31:0] sh;
    logic [7:0] b;
    int npre;
    sh = {op, addr};
    npre = (op == 8'h52) ? 64 : (op == 8'h57) ? 8 : (op == 8'h54 || op == 8'h56) ? 40 : 32;
    rd_q.delete();
    oe_early = 1'b0;
    oe_data = 1'b1;
    sck_out = m3;
    #30 cs_n_out = 1'b0;
    for (int i = 0; i < npre + 8 * nrd; i++) begin
      #24 sck_out = 1'b0;
      // dummy bits toggle so a stuck bit never passes for data
      si_out = (i < 32) ? sh[31 - i] : ~si_out;
      #24 sck_out = 1'b1;
      if (i < npre) begin
        oe_early |= so_oe_in;
      end else begin
        oe_data &= so_oe_in;
        b = {b[6:0], so_in};
        if ((i - npre) % 8 == 7) begin
          rd_q.push_back(b);
        end
      end
    end
    #24 sck_out = m3;
    #10 cs_n_out = 1'b1;
    si_out = ~si_out;
    // cs stays high long enough for the core to see the frame end
    #100;
  endtask
endmodule
`default_nettype wire

// ### sfrc_core_tb.sv
/*
  Self-checking bench for sfrc_core: the program path fills two pages,
  the host model runs read, transfer, compare and status frames.
  Assumes sfrc_host drives the link and the core carries its assertions.
*/
`timescale 1ns/10ps
`default_nettype none
module sfrc_core_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [9:0] page;
    logic [8:0] off;
    logic [9:0] src;
    logic m3;
  } sfrc_row_s;

  logic clk_in = 1'b0;
  logic reset_n_in;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic prog_we = 1'b0;
  logic [9:0] prog_page = 10'h000;
  logic [8:0] prog_byte = 9'h000;
  logic [7:0] prog_data = 8'h00;
  logic prog_busy = 1'b0;
  logic prog_buf_sel = 1'b0;
  logic [8:0] prog_buf_byte = 9'h000;
  logic [7:0] buf_data;
  logic ready;
  logic [7:0] st;
  int err_total = 0;
  int n_compared = 0;
  sfrc_row_s rows [4];

  always #10 clk_in = ~clk_in;

  sfrc_core #(.COPY_CYCLES(300)) sfrc_core_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .prog_we_in(prog_we), .prog_page_in(prog_page), .prog_byte_in(prog_byte),
    .prog_data_in(prog_data), .prog_busy_in(prog_busy), .prog_buf_sel_in(prog_buf_sel),
    .prog_buf_byte_in(prog_buf_byte), .prog_buf_data_out(buf_data), .ready_out(ready));

  sfrc_host sfrc_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [9:0] p, input int o);
    return o[7:0] ^ {p[3:0], 4'hA};
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] p, input int o, input logic [7:0] d);
    @(posedge clk_in);
    prog_we <= 1'b1;
    prog_page <= p;
    prog_byte <= o[8:0];
    prog_data <= d;
    @(posedge clk_in);
    prog_we <= 1'b0;
  endtask

  task automatic status();
    sfrc_host_i.frame(8'h57, 24'h000000, 2, 1'b0);
    st = sfrc_host_i.rd_q[1];
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    chk1(ready, 1'b1);
  endtask

  // background job, then a status read while it still runs
  task automatic job(input logic [7:0] op, input logic [9:0] p);
    sfrc_host_i.frame(op, {5'h00, p, 9'h000}, 0, 1'b0);
    status();
    chk1(st[7], 1'b0);
    chk1(ready, 1'b0);
    wait_ready();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // driven at time zero by nba so the asynchronous reset sees an edge
    reset_n_in <= 1'b0;
    rows[0] = '{8'h52, 10'd5, 9'd262, 10'd5, 1'b0};
    rows[1] = '{8'h52, 10'd9, 9'd0, 10'd9, 1'b1};
    rows[2] = '{8'h54, 10'd0, 9'd263, 10'd5, 1'b0};
    rows[3] = '{8'h56, 10'd0, 9'd10, 10'd9, 1'b1};
    repeat (3) @(posedge clk_in);
    chk1(so_oe, 1'b0);
    chk1(ready, 1'b0);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk1(ready, 1'b1);
    tdone("reset");
    for (int o = 0; o < 264; o++) begin
      wr(10'd5, o, pat(10'd5, o));
      wr(10'd9, o, pat(10'd9, o));
    end
    job(8'h53, 10'd5);
    job(8'h55, 10'd9);
    tdone("transfer");
    foreach (rows[r]) begin
      sfrc_host_i.frame(rows[r].op, (rows[r].op == 8'h52) ? {5'h00, rows[r].page,
        rows[r].off} : {15'h0000, rows[r].off}, 3, rows[r].m3);
      for (int k = 0; k < 3; k++) begin
        chk8(sfrc_host_i.rd_q[k], pat(rows[r].src, (rows[r].off + k) % 264));
      end
      chk1(sfrc_host_i.oe_early, 1'b0);
      chk1(sfrc_host_i.oe_data, 1'b1);
      chk1(so_oe, 1'b0);
    end
    tdone("reads");
    job(8'h60, 10'd5);
    status();
    chk1(st[6], 1'b0);
    wr(10'd5, 100, pat(10'd5, 100) ^ 8'h01);
    job(8'h60, 10'd5);
    status();
    chk1(st[6], 1'b1);
    job(8'h61, 10'd9);
    status();
    chk1(st[6], 1'b0);
    tdone("compare");
    @(posedge clk_in);
    prog_buf_sel <= 1'b1;
    prog_buf_byte <= 9'd7;
    prog_busy <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk8(buf_data, pat(10'd9, 7));
    status();
    chk1(st[7], 1'b0);
    @(posedge clk_in);
    prog_busy <= 1'b0;
    wait_ready();
    tdone("program path");
    end_sim();
  end

  initial begin
    // tests need about 80 us; five times that is a hang
    #400000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
